// ### rtl/isad_pkg.sv
// Purpose: constants for the input sync auto-detect unit
// Assumes: byte-wide register port, one 250 MHz system clock
// Notes: register addresses are the byte addresses of the register port
//
// Contract
// - count hsync low pulse in pixel clocks, 8-bit read-only
// - count hsync period in pixel clocks, 12-bit split over two bytes
// - count vsync low pulse in hsync lines, 8-bit read-only
// - count vsync period in hsync lines, 11-bit read-only
// - pixel-clock sync measurement always runs, no software start or stop
// - count hsync high level in system clocks, 12-bit read-only
// - count hsync low level in system clocks, 12-bit read-only
// - mode-change bit set when vsync period varies over 8 lines
// - mode change with its enable set drives the interrupt pin
// - mode change also latches a pollable interrupt flag
// - field rate bit reads 0 for 50 Hz, 1 for 60 Hz
// - field info bit 0 when even/odd alternation present, else 1
// - no hsync toggle in 2047 clocks sets no-signal and loss flags
// - read-only bit shows normal (0) or free-run blank (1) output
// - read-only bit shows active auto-switch configuration 0 or 1
// - field parity bit 0 even, 1 odd
// - 15-bit count of line buffer overflow and underflow events
// - data-enable measurement result is 12-bit read-only
// - measure selector picks hsync/vsync low/high pulse, resets to 00
// - source selector picks hsync pin, vsync pin, decoder syncs, resets 00
package isad_pkg;
    localparam int ADDR_W = 11;
    localparam logic [10:0] ADDR_INT_FLAG = 11'h002;
    localparam logic [10:0] ADDR_INT_EN = 11'h004;
    localparam logic [10:0] ADDR_DE_CTRL = 11'h04E;
    localparam logic [10:0] ADDR_HS_LOW_PCLK = 11'h160;
    localparam logic [10:0] ADDR_HS_TOT_PCLK = 11'h161;
    localparam logic [10:0] ADDR_VS_LOW_LINES = 11'h162;
    localparam logic [10:0] ADDR_VS_TOT_LINES = 11'h163;
    localparam logic [10:0] ADDR_TOT_HIGH = 11'h164;
    localparam logic [10:0] ADDR_HS_HIGH_SYS = 11'h165;
    localparam logic [10:0] ADDR_HS_LOW_SYS = 11'h166;
    localparam logic [10:0] ADDR_HS_SYS_HIGH = 11'h167;
    localparam logic [10:0] ADDR_FAULT_LO = 11'h168;
    localparam logic [10:0] ADDR_FAULT_HI = 11'h169;
    localparam logic [10:0] ADDR_STATUS = 11'h16A;
    localparam logic [10:0] ADDR_DE_LO = 11'h16B;
    localparam logic [10:0] ADDR_DE_HI = 11'h16C;
    // interrupt flag / enable bit positions
    localparam int BIT_LOSS0 = 0;
    localparam int BIT_LOSS1 = 1;
    localparam int BIT_MODE_CHG = 2;
    // control field positions inside the data-enable control byte
    localparam int DE_SEL_LSB = 0;
    localparam int DE_SRC_LSB = 2;
    localparam logic [1:0] DE_SEL_RESET = 2'h0;
    localparam logic [1:0] DE_SRC_RESET = 2'h0;
    localparam logic [2:0] INT_EN_RESET = 3'h0;
    // data-enable source codes
    localparam logic [1:0] DE_SRC_HS_PIN = 2'h0;
    localparam logic [1:0] DE_SRC_VS_PIN = 2'h1;
    localparam logic [1:0] DE_SRC_DEC_HS = 2'h2;
    localparam logic [1:0] DE_SRC_DEC_VS = 2'h3;
    // timing counts
    localparam logic [10:0] NO_SIGNAL_CYCLES = 11'd2047;
    localparam logic [10:0] MODE_CHG_LINES = 11'd8;
    localparam logic [10:0] RATE_SPLIT_LINES = 11'd575;
endpackage : isad_pkg

// ### rtl/isad_sync.sv
// Purpose: two-flop synchroniser with edge pulses
// Assumes: input may be asynchronous to clock
// Notes: edges come from the second and third flops only
`timescale 1ns/10ps
module isad_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
        logic [WIDTH-1:0] prev;
    } isad_sync_state_t;

    isad_sync_state_t st;
    isad_sync_state_t next_st;

    always_comb begin
        next_st.meta = async_in;
        next_st.stable = st.meta;
        next_st.prev = st.stable;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.stable;
    assign rise = st.stable & ~st.prev;
    assign fall = ~st.stable & st.prev;
endmodule : isad_sync

// ### rtl/isad_meter.sv
// Purpose: measures low, high and falling-to-falling period of a level
// Assumes: level is already in the clock domain; tick marks one unit
// Notes: counters saturate so a stuck input never wraps to a small value
`timescale 1ns/10ps
module isad_meter #(
    parameter int WIDTH = 12
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic level,
    input wire logic tick,
    output logic [WIDTH-1:0] low_width,
    output logic [WIDTH-1:0] high_width,
    output logic [WIDTH-1:0] period
);
    typedef struct packed {
        logic prev;
        logic [WIDTH-1:0] run_cnt;
        logic [WIDTH-1:0] per_cnt;
        logic [WIDTH-1:0] low;
        logic [WIDTH-1:0] high;
        logic [WIDTH-1:0] per;
    } isad_meter_state_t;

    isad_meter_state_t st;
    isad_meter_state_t next_st;

    function automatic logic [WIDTH-1:0] sat_inc(input logic [WIDTH-1:0] v, input logic en);
        if (en && (v != '1)) begin
            return v + 1'b1;
        end
        return v;
    endfunction : sat_inc

    always_comb begin
        next_st = st;
        next_st.prev = level;
        next_st.run_cnt = sat_inc(st.run_cnt, tick);
        next_st.per_cnt = sat_inc(st.per_cnt, tick);
        if (level != st.prev) begin
            // count restarts so the unit on the edge belongs to the new phase
            next_st.run_cnt = sat_inc('0, tick);
            if (level) begin
                next_st.low = st.run_cnt;
            end else begin
                next_st.high = st.run_cnt;
                next_st.per = st.per_cnt;
                next_st.per_cnt = sat_inc('0, tick);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign low_width = st.low;
    assign high_width = st.high;
    assign period = st.per;
endmodule : isad_meter

// ### rtl/isad_input_sync_auto_detect.sv
// Purpose: input sync auto-detection, status registers and interrupt pin
// Assumes: byte register port on the system clock; sync pins are asynchronous
// Notes: pixel clock is sampled as a pin, so it must stay below half the
//        system clock; read data appears one cycle after the address
`timescale 1ns/10ps
module isad_input_sync_auto_detect (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic pclk_pin,
    input wire logic hsync_pin,
    input wire logic vsync_pin,
    input wire logic internal_decoder_hsync,
    input wire logic internal_decoder_vsync,
    input wire logic line_buf_fault,
    input wire logic free_run_state,
    input wire logic input_config_state,
    input wire logic [10:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic int_out
);
    typedef struct packed {
        logic [2:0] int_flag;
        logic [2:0] int_en;
        logic [1:0] de_measure_select;
        logic [1:0] de_source_select;
        logic mode_change_flag;
        logic field_rate_flag;
        logic field_parity_flag;
        logic field_info_absent_flag;
        logic signal_lost_flag;
        logic have_prev;
        logic saw_fall;
        logic vs_fall_d;
        logic [10:0] lost_cnt;
        logic [14:0] line_buffer_fault_count;
        logic [10:0] prev_vtotal;
        logic [11:0] line_pos;
        logic irq;
        logic [7:0] rdata;
    } isad_top_state_t;

    isad_top_state_t st;
    isad_top_state_t next_st;

    logic [2:0] pin_level;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;
    logic pclk_rise;
    logic hs_level;
    logic hs_fall;
    logic hs_edge;
    logic vs_level;
    logic vs_fall;
    logic [11:0] hs_low_pclk_w;
    logic [11:0] hs_tot_pclk;
    logic [11:0] hs_high_pclk_w;
    logic [10:0] vs_low_lines;
    logic [10:0] vs_tot_lines;
    logic [10:0] vs_high_lines_w;
    logic [11:0] hs_high_sys;
    logic [11:0] hs_low_sys;
    logic [11:0] hs_per_sys_w;
    logic de_level;
    logic de_tick;
    logic [11:0] de_low;
    logic [11:0] de_high;
    logic [11:0] de_per_w;
    logic [11:0] de_result;
    logic mode_chg_event;
    logic lost_event;
    logic [12:0] line_len;

    function automatic logic [10:0] abs_diff(input logic [10:0] a, input logic [10:0] b);
        return (a > b) ? (a - b) : (b - a);
    endfunction : abs_diff

    function automatic logic addr_is(input logic [10:0] a, input logic [10:0] ref_addr);
        return a == ref_addr;
    endfunction : addr_is

    isad_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in({vsync_pin, hsync_pin, pclk_pin}),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    assign pclk_rise = pin_rise[0];
    assign hs_level = pin_level[1];
    assign hs_fall = pin_fall[1];
    assign hs_edge = pin_rise[1] | pin_fall[1];
    assign vs_level = pin_level[2];
    assign vs_fall = pin_fall[2];

    // free-running after reset; nothing in the register map can halt these
    isad_meter #(
        .WIDTH(12)
    ) u_hs_pclk (
        .clock(clock),
        .sys_rst(sys_rst),
        .level(hs_level),
        .tick(pclk_rise),
        .low_width(hs_low_pclk_w),
        .high_width(hs_high_pclk_w),
        .period(hs_tot_pclk)
    );

    isad_meter #(
        .WIDTH(11)
    ) u_vs_lines (
        .clock(clock),
        .sys_rst(sys_rst),
        .level(vs_level),
        .tick(hs_fall),
        .low_width(vs_low_lines),
        .high_width(vs_high_lines_w),
        .period(vs_tot_lines)
    );

    isad_meter #(
        .WIDTH(12)
    ) u_hs_sys (
        .clock(clock),
        .sys_rst(sys_rst),
        .level(hs_level),
        .tick(1'b1),
        .low_width(hs_low_sys),
        .high_width(hs_high_sys),
        .period(hs_per_sys_w)
    );

    // source mux; decoder syncs are already on this clock
    always_comb begin
        case (st.de_source_select)
            isad_pkg::DE_SRC_HS_PIN: de_level = hs_level;
            isad_pkg::DE_SRC_VS_PIN: de_level = vs_level;
            isad_pkg::DE_SRC_DEC_HS: de_level = internal_decoder_hsync;
            isad_pkg::DE_SRC_DEC_VS: de_level = internal_decoder_vsync;
            default: de_level = hs_level;
        endcase
    end

    // hsync pulses count in system clocks, vsync pulses in hsync-pin lines
    assign de_tick = st.de_measure_select[1] ? hs_fall : 1'b1;

    isad_meter #(
        .WIDTH(12)
    ) u_de (
        .clock(clock),
        .sys_rst(sys_rst),
        .level(de_level),
        .tick(de_tick),
        .low_width(de_low),
        .high_width(de_high),
        .period(de_per_w)
    );

    assign de_result = st.de_measure_select[0] ? de_high : de_low;

    assign line_len = {1'b0, hs_high_sys} + {1'b0, hs_low_sys};
    assign mode_chg_event = st.vs_fall_d && st.have_prev &&
        (abs_diff(vs_tot_lines, st.prev_vtotal) > isad_pkg::MODE_CHG_LINES);
    assign lost_event = !hs_edge && !st.signal_lost_flag &&
        (st.lost_cnt == isad_pkg::NO_SIGNAL_CYCLES - 11'd1);

    always_comb begin
        next_st = st;
        next_st.vs_fall_d = vs_fall;
        // position inside the line, used to tell the field from vsync phase
        if (hs_fall) begin
            next_st.line_pos = 12'h000;
        end else if (st.line_pos != 12'hFFF) begin
            next_st.line_pos = st.line_pos + 12'h001;
        end
        if (vs_fall) begin
            next_st.field_parity_flag = ({1'b0, st.line_pos} >= (line_len >> 1));
            next_st.field_info_absent_flag =
                (({1'b0, st.line_pos} >= (line_len >> 1)) == st.field_parity_flag);
        end
        // meters latch one cycle after the edge, so compare on the delayed pulse
        // the first period after reset runs from reset, not from an edge, so it is
        // stored but never compared; otherwise start-up would fake a mode change
        if (st.vs_fall_d) begin
            next_st.saw_fall = 1'b1;
            next_st.have_prev = st.saw_fall;
            next_st.prev_vtotal = vs_tot_lines;
            next_st.mode_change_flag = mode_chg_event;
            next_st.field_rate_flag = (vs_tot_lines < isad_pkg::RATE_SPLIT_LINES);
        end
        if (hs_edge) begin
            next_st.lost_cnt = 11'h000;
            next_st.signal_lost_flag = 1'b0;
        end else begin
            if (st.lost_cnt != isad_pkg::NO_SIGNAL_CYCLES) begin
                next_st.lost_cnt = st.lost_cnt + 11'h001;
            end
            if (lost_event) begin
                next_st.signal_lost_flag = 1'b1;
            end
        end
        if (line_buf_fault && (st.line_buffer_fault_count != 15'h7FFF)) begin
            next_st.line_buffer_fault_count = st.line_buffer_fault_count + 15'h0001;
        end
        // register writes; flags are write-one-to-clear
        if (reg_wr && addr_is(reg_addr, isad_pkg::ADDR_INT_FLAG)) begin
            next_st.int_flag = st.int_flag & ~reg_wdata[2:0];
        end
        if (reg_wr && addr_is(reg_addr, isad_pkg::ADDR_INT_EN)) begin
            next_st.int_en = reg_wdata[2:0];
        end
        if (reg_wr && addr_is(reg_addr, isad_pkg::ADDR_DE_CTRL)) begin
            next_st.de_measure_select = reg_wdata[isad_pkg::DE_SEL_LSB +: 2];
            next_st.de_source_select = reg_wdata[isad_pkg::DE_SRC_LSB +: 2];
        end
        // a new event in the clearing cycle still sets its flag
        if (mode_chg_event) begin
            next_st.int_flag[isad_pkg::BIT_MODE_CHG] = 1'b1;
        end
        if (lost_event) begin
            next_st.int_flag[isad_pkg::BIT_LOSS0] = 1'b1;
            next_st.int_flag[isad_pkg::BIT_LOSS1] = 1'b1;
        end
        next_st.irq = |(st.int_flag & st.int_en);
        case (reg_addr)
            isad_pkg::ADDR_INT_FLAG: next_st.rdata = {5'h00, st.int_flag};
            isad_pkg::ADDR_INT_EN: next_st.rdata = {5'h00, st.int_en};
            isad_pkg::ADDR_DE_CTRL: next_st.rdata = {4'h0, st.de_source_select,
                st.de_measure_select};
            isad_pkg::ADDR_HS_LOW_PCLK: next_st.rdata = hs_low_pclk_w[7:0];
            isad_pkg::ADDR_HS_TOT_PCLK: next_st.rdata = hs_tot_pclk[7:0];
            isad_pkg::ADDR_VS_LOW_LINES: next_st.rdata = vs_low_lines[7:0];
            isad_pkg::ADDR_VS_TOT_LINES: next_st.rdata = vs_tot_lines[7:0];
            isad_pkg::ADDR_TOT_HIGH: next_st.rdata = {hs_tot_pclk[11:8], 1'b0,
                vs_tot_lines[10:8]};
            isad_pkg::ADDR_HS_HIGH_SYS: next_st.rdata = hs_high_sys[7:0];
            isad_pkg::ADDR_HS_LOW_SYS: next_st.rdata = hs_low_sys[7:0];
            isad_pkg::ADDR_HS_SYS_HIGH: next_st.rdata = {hs_high_sys[11:8],
                hs_low_sys[11:8]};
            isad_pkg::ADDR_FAULT_LO: next_st.rdata = st.line_buffer_fault_count[7:0];
            isad_pkg::ADDR_FAULT_HI: next_st.rdata = {1'b0,
                st.line_buffer_fault_count[14:8]};
            isad_pkg::ADDR_STATUS: next_st.rdata = {1'b0, st.field_parity_flag,
                input_config_state, free_run_state, st.signal_lost_flag,
                st.field_info_absent_flag, st.field_rate_flag,
                st.mode_change_flag};
            isad_pkg::ADDR_DE_LO: next_st.rdata = de_result[7:0];
            isad_pkg::ADDR_DE_HI: next_st.rdata = {4'h0, de_result[11:8]};
            default: next_st.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st <= '0;
            st.int_en <= isad_pkg::INT_EN_RESET;
            st.de_measure_select <= isad_pkg::DE_SEL_RESET;
            st.de_source_select <= isad_pkg::DE_SRC_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign int_out = st.irq;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    chk_lost_timeout: assert property (
        lost_event |=> st.signal_lost_flag && st.int_flag[1:0] == 2'h3
    ) else $error("no-signal timeout did not set status and flags");

    chk_lost_release: assert property (
        hs_edge |=> !st.signal_lost_flag
    ) else $error("hsync toggle did not clear no-signal status");

    chk_lost_count: assert property (
        st.signal_lost_flag && !$past(st.signal_lost_flag) |->
            $past(st.lost_cnt) == isad_pkg::NO_SIGNAL_CYCLES - 11'd1
    ) else $error("no-signal raised at wrong count");

    chk_modechg_flag: assert property (
        mode_chg_event |=> st.int_flag[isad_pkg::BIT_MODE_CHG] && st.mode_change_flag
    ) else $error("mode change not recorded");

    chk_modechg_quiet: assert property (
        st.vs_fall_d && st.have_prev && !mode_chg_event |=> !st.mode_change_flag
    ) else $error("mode change bit set without large variation");

    chk_irq_gate: assert property (
        st.int_flag[2] && st.int_en[2] |=> int_out
    ) else $error("enabled mode change did not reach interrupt pin");

    chk_irq_quiet: assert property (
        (st.int_flag & st.int_en) == 3'h0 |=> !int_out
    ) else $error("interrupt pin raised without enabled flag");

    chk_select_reset: assert property (
        $fell(sys_rst) |-> st.de_measure_select == 2'h0 && st.de_source_select == 2'h0
    ) else $error("data-enable selectors not reset to zero");

    chk_fault_count: assert property (
        line_buf_fault && st.line_buffer_fault_count != 15'h7FFF |=>
            st.line_buffer_fault_count == $past(st.line_buffer_fault_count) + 15'h0001
    ) else $error("line buffer fault not counted");

    chk_rate_bit: assert property (
        st.vs_fall_d |=> st.field_rate_flag == ($past(vs_tot_lines) < 11'd575)
    ) else $error("field rate bit wrong");

    chk_status_read: assert property (
        reg_addr == isad_pkg::ADDR_STATUS |=> reg_rdata[3] == $past(st.signal_lost_flag)
    ) else $error("status read does not show no-signal bit");

    chk_first_compare: assert property (
        st.vs_fall_d && !st.have_prev |=> !st.mode_change_flag
    ) else $error("mode change flagged without a previous full period");

    chk_lost_quiet: assert property (
        !st.signal_lost_flag && st.lost_cnt < isad_pkg::NO_SIGNAL_CYCLES - 11'd1
            |=> !st.signal_lost_flag
    ) else $error("no-signal raised before the timeout");

    chk_enable_write: assert property (
        reg_wr && reg_addr == isad_pkg::ADDR_INT_EN |=> st.int_en == $past(reg_wdata[2:0])
    ) else $error("interrupt enable write not taken");

    chk_select_write: assert property (
        reg_wr && reg_addr == isad_pkg::ADDR_DE_CTRL |=>
            {st.de_source_select, st.de_measure_select} == $past(reg_wdata[3:0])
    ) else $error("data-enable selector write not taken");

    chk_fault_hold: assert property (
        !line_buf_fault |=>
            st.line_buffer_fault_count == $past(st.line_buffer_fault_count)
    ) else $error("line buffer fault count moved without an event");
endmodule : isad_input_sync_auto_detect

// ### test/isad_video_source.sv
// Purpose: external video source model driving pixel clock, hsync and vsync
// Assumes: timing inputs are taken at each frame start, so they may change at any time
// Notes: run low freezes hsync at its level, which is how a lost signal looks
`timescale 1ns/10ps
module isad_video_source (
    input wire logic clock,
    input wire logic run,
    input wire logic [7:0] hs_low,
    input wire logic [7:0] hs_high,
    input wire logic [10:0] lines,
    input wire logic [7:0] vs_low,
    output logic pclk_pin,
    output logic hsync_pin,
    output logic vsync_pin
);
    logic [1:0] pdiv = 2'h0;
    logic [8:0] pc = 9'h000;
    logic [10:0] ln = 11'h000;
    logic [7:0] lo_r = 8'h01;
    logic [7:0] hi_r = 8'h01;
    logic [10:0] ln_r = 11'h001;
    logic [7:0] vl_r = 8'h00;
    initial begin
        pclk_pin = 1'b0;
        hsync_pin = 1'b1;
        vsync_pin = 1'b1;
    end
    // pixel clock runs free at a quarter of the system clock
    always @(posedge clock) begin
        pdiv <= pdiv + 2'h1;
        pclk_pin <= pdiv[1];
        if (run) begin
            hsync_pin <= (pc >= {1'b0, lo_r});
            // vsync moves on the hsync rise so no line is split by it
            if (pc == {1'b0, lo_r}) begin
                vsync_pin <= (ln >= {3'h0, vl_r});
            end
            if (pc == {1'b0, lo_r} + {1'b0, hi_r} - 9'h001) begin
                pc <= 9'h000;
                if (ln == ln_r - 11'h001) begin
                    ln <= 11'h000;
                    lo_r <= hs_low;
                    hi_r <= hs_high;
                    ln_r <= lines;
                    vl_r <= vs_low;
                end else begin
                    ln <= ln + 11'h001;
                end
            end else begin
                pc <= pc + 9'h001;
            end
        end
    end
endmodule : isad_video_source

// ### test/input_sync_auto_detect_tb_top.sv
// Purpose: self-checking bench for the input sync auto-detect unit
// Assumes: register reads answer one cycle after the address
// Notes: a new frame length shows at the second vsync fall after it is set;
//        the mode bit stands for one frame only
`timescale 1ns/10ps
module input_sync_auto_detect_tb_top;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic run = 1'b1;
    logic [7:0] hs_low = 8'h08;
    logic [7:0] hs_high = 8'h20;
    logic [10:0] lines = 11'h014;
    logic [7:0] vs_low = 8'h03;
    logic fault = 1'b0;
    logic free_run = 1'b1;
    logic cfg = 1'b0;
    logic [10:0] addr = 11'h000;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic pclk;
    logic hs;
    logic vs;
    logic [7:0] rdata;
    logic irq;
    logic [15:0] v;
    logic [3:0] de_cfg [7] = '{4'h0, 4'h1, 4'h6, 4'h7, 4'h9, 4'hE, 4'h4};
    logic [15:0] de_exp [7] = '{16'h0008, 16'h0020, 16'h0003, 16'h0011, 16'h0020,
        16'h0003, 16'h0078};
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;

    isad_video_source src (.clock(clock), .run(run), .hs_low(hs_low), .hs_high(hs_high),
        .lines(lines), .vs_low(vs_low), .pclk_pin(pclk), .hsync_pin(hs), .vsync_pin(vs));

    isad_input_sync_auto_detect dut (.clock(clock), .sys_rst(sys_rst), .pclk_pin(pclk),
        .hsync_pin(hs), .vsync_pin(vs), .internal_decoder_hsync(hs),
        .internal_decoder_vsync(vs), .line_buf_fault(fault), .free_run_state(free_run),
        .input_config_state(cfg), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
        .reg_rdata(rdata), .int_out(irq));

    initial begin
        forever #2 clock = ~clock;
    end

    task stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    // the whole run needs about 36500 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task rd(input logic [10:0] a, output logic [7:0] d);
        addr = a;
        @(posedge clock);
        #1 d = rdata;
    endtask : rd

    task wr_reg(input logic [10:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clock);
        #1 wr = 1'b0;
        // one idle edge so a following write never re-raises the strobe at once
        @(posedge clock);
        #1;
    endtask : wr_reg

    task rdc(input logic [10:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk({8'h00, d & m}, {8'h00, e});
    endtask : rdc

    // no atomic snapshot: both bytes are read while the input is steady
    task rdw(input logic [10:0] alo, input logic [10:0] ahi, input int sh,
        input logic [7:0] m, output logic [15:0] r);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(alo, lo);
        rd(ahi, hi);
        r = {(hi >> sh) & m, lo};
    endtask : rdw

    task frames(input int n);
        repeat (n) @(negedge vs);
        repeat (16) @(posedge clock);
        #1;
    endtask : frames

    task gap(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : gap

    task meas(input logic [15:0] xl, input logic [15:0] xt, input logic [15:0] yl,
        input logic [15:0] yt, input logic [15:0] sh, input logic [15:0] sl,
        input logic [7:0] st);
        rdw(11'h160, 11'h160, 8, 8'h00, v);
        chk(v, xl);
        rdw(11'h161, 11'h164, 4, 8'h0F, v);
        chk(v, xt);
        rdw(11'h162, 11'h162, 8, 8'h00, v);
        chk(v, yl);
        rdw(11'h163, 11'h164, 0, 8'h07, v);
        chk(v, yt);
        rdw(11'h165, 11'h167, 4, 8'h0F, v);
        chk(v, sh);
        rdw(11'h166, 11'h167, 0, 8'h0F, v);
        chk(v, sl);
        rdc(11'h16A, 8'hFF, st);
    endtask : meas

    initial begin
        repeat (5) @(posedge clock);
        #1 sys_rst = 1'b0;
        rdc(11'h04E, 8'hFF, 8'h00);
        rdc(11'h004, 8'hFF, 8'h00);
        frames(3);
        meas(16'h0002, 16'h000A, 16'h0003, 16'h0014, 16'h0020, 16'h0008, 8'h16);
        rdw(11'h16B, 11'h16C, 0, 8'h0F, v);
        chk(v, 16'h0008);
        repeat (5) begin
            fault = 1'b1;
            gap(1);
            fault = 1'b0;
            gap(1);
        end
        rdw(11'h168, 11'h169, 0, 8'h7F, v);
        chk(v, 16'h0005);
        wr_reg(11'h160, 8'hFF);
        rdc(11'h160, 8'hFF, 8'h02);
        rdc(11'h100, 8'hFF, 8'h00);
        $display("test static done");
        for (int i = 0; i < 7; i++) begin
            wr_reg(11'h04E, {4'h0, de_cfg[i]});
            rdc(11'h04E, 8'hFF, {4'h0, de_cfg[i]});
            frames(2);
            rdw(11'h16B, 11'h16C, 0, 8'h0F, v);
            chk(v, de_exp[i]);
        end
        wr_reg(11'h04E, 8'h00);
        $display("test data_enable done");
        wr_reg(11'h004, 8'h04);
        lines = 11'd28;
        frames(3);
        rdc(11'h16A, 8'hFF, 8'h16);
        rdc(11'h002, 8'hFF, 8'h00);
        chk({15'h0000, irq}, 16'h0000);
        lines = 11'd37;
        frames(2);
        rdc(11'h16A, 8'hFF, 8'h17);
        rdc(11'h002, 8'hFF, 8'h04);
        chk({15'h0000, irq}, 16'h0001);
        wr_reg(11'h002, 8'h04);
        gap(3);
        rdc(11'h002, 8'hFF, 8'h00);
        chk({15'h0000, irq}, 16'h0000);
        $display("test mode_change done");
        hs_low = 8'h04;
        hs_high = 8'h08;
        lines = 11'd600;
        free_run = 1'b0;
        cfg = 1'b1;
        frames(3);
        meas(16'h0001, 16'h0003, 16'h0003, 16'h0258, 16'h0008, 16'h0004, 8'h24);
        $display("test field_rate done");
        wr_reg(11'h002, 8'h07);
        wr_reg(11'h004, 8'h03);
        run = 1'b0;
        gap(2000);
        rdc(11'h16A, 8'h08, 8'h00);
        gap(60);
        rdc(11'h16A, 8'h08, 8'h08);
        rdc(11'h002, 8'h03, 8'h03);
        chk({15'h0000, irq}, 16'h0001);
        run = 1'b1;
        gap(40);
        rdc(11'h16A, 8'h08, 8'h00);
        wr_reg(11'h002, 8'h03);
        gap(3);
        rdc(11'h002, 8'h03, 8'h00);
        chk({15'h0000, irq}, 16'h0000);
        $display("test no_signal done");
        stop_test();
    end
endmodule : input_sync_auto_detect_tb_top
